// [logic/icr_params.svh]
// Register map, field positions and reset values of the command registers
`ifndef ICR_PARAMS_SVH
`define ICR_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ICR_A_SVR_BASE 32'hfffff080
`define ICR_A_SVR_MASK 32'hffffff80
`define ICR_A_IVR 32'hfffff100
`define ICR_A_FVR 32'hfffff104
`define ICR_A_ISR 32'hfffff108
`define ICR_A_IPR 32'hfffff10c
`define ICR_A_IMR 32'hfffff110
`define ICR_A_CISR 32'hfffff114
`define ICR_A_IECR 32'hfffff120
`define ICR_A_IDCR 32'hfffff124
`define ICR_A_ICCR 32'hfffff128
`define ICR_A_ISCR 32'hfffff12c
`define ICR_A_EOICR 32'hfffff130
`define ICR_A_SPU 32'hfffff134
`define ICR_A_DCR 32'hfffff138
`define ICR_A_FFER 32'hfffff140
`define ICR_A_FFDR 32'hfffff144
`define ICR_A_FFSR 32'hfffff148
`define ICR_A_EVT_STAT 32'hfffff150
`define ICR_A_EVT_CLR 32'hfffff154
`define ICR_A_EVT_EN 32'hfffff158

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define ICR_DCR_PROTECT_EN 0
`define ICR_DCR_LINE_MASK 1
`define ICR_FAST_SRC 0
`define ICR_FAST_SRC_ID 5'h00
`define ICR_EV_EOI 0
`define ICR_EV_SPUR_N 1
`define ICR_EV_SPUR_F 2
`define ICR_RST_WORD 32'h0000_0000
`define ICR_RST_DCR 2'h0
`define ICR_RST_EVT 3'h0
`define ICR_NO_FORCE_SRC0 32'hffff_fffe

`endif

// [logic/icr_pkg.sv]
// Types shared by the command register block
package icr_pkg;

	// Bus handshake states, Gray coded along idle, wait, done
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_DONE = 2'h3
	} icr_state_t;

	typedef struct packed {
		icr_state_t st;
		logic [31:0] pend;
		logic [31:0] mask;
		logic [31:0] ffs;
		logic [31:0] spu;
		logic [1:0] dcr;
		logic cur_valid;
		logic [4:0] cur_id;
		logic [31:0] src_prev;
		logic [2:0] evt_stat;
		logic [2:0] evt_en;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic normal_irq_out_n_n;
		logic fast_irq_out_n_n;
		logic irq;
	} icr_regs_t;

endpackage

// [logic/icr_vec_mem.sv]
// Source vector memory: one write port, registered read port
`timescale 1ns/1ps
module icr_vec_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	// Clock
	input wire logic core_clk,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// No reset on the array; software programs every vector it uses
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule

// [logic/icr_cmd_regs.sv]
// Interrupt command registers, vector reads and processor request lines
//
// Overview of operation
// - Set command marks written-one sources pending
// - Any end-of-interrupt write ends current treatment
// - Spurious vector register, read-write, resets zero
// - Spurious normal vector read returns spurious value
// - Spurious fast vector read returns spurious value
// - Debug bit 0 turns protection mode on
// - Debug bit 1 holds both request lines inactive
// - Fast forcing enable sets per-source forcing
// - Fast forcing disable clears per-source forcing
// - Fast forcing status shows forcing, bit0 zero
// - Normal vector read returns current source vector
// - Fast vector read returns source zero vector
// - Clear command drops written-one pending sources
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "icr_params.svh"
module icr_cmd_regs
	import icr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt sources, active high
	input wire logic [31:0] src_irq,
	// Processor request lines, active low
	output logic normal_irq_out_n,
	output logic fast_irq_out_n,
	// Block event interrupt
	output logic irq_out
);

	// ----------------------------------------------------------------
	// State and derived terms
	// ----------------------------------------------------------------
	icr_regs_t s_r;
	icr_regs_t s_nxt;

	logic [31:0] normal_req;
	logic [31:0] fast_req;
	logic best_found;
	logic [4:0] best_id;
	logic [4:0] mem_raddr;
	logic [31:0] mem_rdata;
	logic mem_we;
	logic in_wait;
	logic svr_hit;

	function automatic logic [5:0] first_set(input logic [31:0] v);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
		return a == b;
	endfunction

	assign normal_req = s_r.pend & s_r.mask & ~s_r.ffs &
		`ICR_NO_FORCE_SRC0;
	assign fast_req = s_r.pend & s_r.mask & (s_r.ffs | ~`ICR_NO_FORCE_SRC0);
	assign {best_found, best_id} = first_set(normal_req);

	assign in_wait = s_r.st == ST_WAIT;
	assign svr_hit = (paddr & `ICR_A_SVR_MASK) == `ICR_A_SVR_BASE;
	assign mem_we = in_wait && pwrite && svr_hit;

	// ----------------------------------------------------------------
	// Vector memory, read address chosen one cycle ahead of the answer
	// ----------------------------------------------------------------
	always_comb begin
		if (hit(paddr, `ICR_A_IVR)) begin
			mem_raddr = best_id;
		end else if (hit(paddr, `ICR_A_FVR)) begin
			mem_raddr = `ICR_FAST_SRC_ID;
		end else begin
			mem_raddr = paddr[6:2];
		end
	end

	icr_vec_mem #(
		.WIDTH(32),
		.DEPTH(32),
		.AW(5)
	) u_vec_mem (
		.core_clk(core_clk),
		.we(mem_we),
		.waddr(paddr[6:2]),
		.wdata(pwdata),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] set_b;
		logic [31:0] clr_b;
		logic [2:0] ev;
		logic take;
		logic wr;
		logic rd;
		set_b = s_r.src_prev ^ src_irq;
		set_b = set_b & src_irq;
		clr_b = `ICR_RST_WORD;
		ev = `ICR_RST_EVT;
		take = 1'b0;
		wr = in_wait && pwrite;
		rd = in_wait && !pwrite;
		s_nxt = s_r;
		s_nxt.src_prev = src_irq;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		case (s_r.st)
			ST_IDLE: begin
				if (psel && penable) begin
					s_nxt.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				s_nxt.st = ST_DONE;
				s_nxt.pready = 1'b1;
			end
			ST_DONE: begin
				s_nxt.st = ST_IDLE;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		// Reads: data and their side effects in the wait cycle
		if (rd) begin
			s_nxt.prdata = `ICR_RST_WORD;
			if (svr_hit) begin
				s_nxt.prdata = mem_rdata;
			end else if (hit(paddr, `ICR_A_IVR)) begin
				s_nxt.prdata = best_found ? mem_rdata : s_r.spu;
				if (!s_r.dcr[`ICR_DCR_PROTECT_EN]) begin
					take = 1'b1;
				end
			end else if (hit(paddr, `ICR_A_FVR)) begin
				s_nxt.prdata = (|fast_req) ? mem_rdata : s_r.spu;
				if (|fast_req) begin
					clr_b[`ICR_FAST_SRC] = 1'b1;
				end else begin
					ev[`ICR_EV_SPUR_F] = 1'b1;
				end
			end else if (hit(paddr, `ICR_A_ISR)) begin
				s_nxt.prdata = {27'h0, s_r.cur_id};
			end else if (hit(paddr, `ICR_A_IPR)) begin
				s_nxt.prdata = s_r.pend;
			end else if (hit(paddr, `ICR_A_IMR)) begin
				s_nxt.prdata = s_r.mask;
			end else if (hit(paddr, `ICR_A_CISR)) begin
				s_nxt.prdata = {30'h0, ~s_r.normal_irq_out_n_n, ~s_r.fast_irq_out_n_n};
			end else if (hit(paddr, `ICR_A_SPU)) begin
				s_nxt.prdata = s_r.spu;
			end else if (hit(paddr, `ICR_A_DCR)) begin
				s_nxt.prdata = {30'h0, s_r.dcr};
			end else if (hit(paddr, `ICR_A_FFSR)) begin
				s_nxt.prdata = s_r.ffs;
			end else if (hit(paddr, `ICR_A_EVT_STAT)) begin
				s_nxt.prdata = {29'h0, s_r.evt_stat};
			end else if (hit(paddr, `ICR_A_EVT_EN)) begin
				s_nxt.prdata = {29'h0, s_r.evt_en};
			end else if (!(hit(paddr, `ICR_A_IECR) ||
				hit(paddr, `ICR_A_IDCR) || hit(paddr, `ICR_A_ICCR) ||
				hit(paddr, `ICR_A_ISCR) || hit(paddr, `ICR_A_EOICR) ||
				hit(paddr, `ICR_A_FFER) || hit(paddr, `ICR_A_FFDR) ||
				hit(paddr, `ICR_A_EVT_CLR))) begin
				s_nxt.pslverr = 1'b1;
			end
		end
		// Writes
		if (wr) begin
			if (svr_hit) begin
				s_nxt.pslverr = 1'b0;
			end else if (hit(paddr, `ICR_A_IVR)) begin
				// write takes the interrupt in protection mode
				take = s_r.dcr[`ICR_DCR_PROTECT_EN];
			end else if (hit(paddr, `ICR_A_IECR)) begin
				s_nxt.mask = s_r.mask | pwdata;
			end else if (hit(paddr, `ICR_A_IDCR)) begin
				s_nxt.mask = s_r.mask & ~pwdata;
			end else if (hit(paddr, `ICR_A_ICCR)) begin
				clr_b = clr_b | pwdata;
			end else if (hit(paddr, `ICR_A_ISCR)) begin
				set_b = set_b | pwdata;
			end else if (hit(paddr, `ICR_A_EOICR)) begin
				s_nxt.cur_valid = 1'b0;
				ev[`ICR_EV_EOI] = 1'b1;
			end else if (hit(paddr, `ICR_A_SPU)) begin
				s_nxt.spu = pwdata;
			end else if (hit(paddr, `ICR_A_DCR)) begin
				s_nxt.dcr = pwdata[1:0];
			end else if (hit(paddr, `ICR_A_FFER)) begin
				s_nxt.ffs = (s_r.ffs | pwdata) & `ICR_NO_FORCE_SRC0;
			end else if (hit(paddr, `ICR_A_FFDR)) begin
				s_nxt.ffs = s_r.ffs & ~pwdata;
			end else if (hit(paddr, `ICR_A_EVT_CLR)) begin
				s_nxt.evt_stat = s_r.evt_stat & ~pwdata[2:0];
			end else if (hit(paddr, `ICR_A_EVT_EN)) begin
				s_nxt.evt_en = pwdata[2:0];
			end else begin
				s_nxt.pslverr = 1'b1;
			end
		end
		// Taking the current interrupt; no current one means spurious
		if (take) begin
			if (best_found) begin
				s_nxt.cur_valid = 1'b1;
				s_nxt.cur_id = best_id;
				clr_b[best_id] = 1'b1;
			end else begin
				ev[`ICR_EV_SPUR_N] = 1'b1;
			end
		end
		// A new source edge or set wins over a clear in the same cycle
		s_nxt.pend = (s_r.pend & ~clr_b) | set_b;
		s_nxt.evt_stat = s_nxt.evt_stat | ev;
		s_nxt.irq = |(s_nxt.evt_stat & s_nxt.evt_en);
		// general mask holds both lines high
		s_nxt.normal_irq_out_n_n = s_r.dcr[`ICR_DCR_LINE_MASK] ||
			!((|normal_req) && !s_r.cur_valid);
		s_nxt.fast_irq_out_n_n = s_r.dcr[`ICR_DCR_LINE_MASK] || !(|fast_req);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.normal_irq_out_n_n <= 1'b1;
			s_r.fast_irq_out_n_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign normal_irq_out_n = s_r.normal_irq_out_n_n;
	assign fast_irq_out_n = s_r.fast_irq_out_n_n;
	assign irq_out = s_r.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	logic w_wait;
	logic r_wait;
	assign w_wait = in_wait && pwrite;
	assign r_wait = in_wait && !pwrite;

	sequence s_ivr_read_spur;
		r_wait && hit(paddr, `ICR_A_IVR) && !best_found;
	endsequence

	property p_set_cmd;
		w_wait && hit(paddr, `ICR_A_ISCR) |=>
			(s_r.pend & $past(pwdata)) == $past(pwdata);
	endproperty
	a_set_cmd: assert property (p_set_cmd)
		else $error("set command did not make sources pending");

	property p_eoi;
		w_wait && hit(paddr, `ICR_A_EOICR) |=> !s_r.cur_valid;
	endproperty
	a_eoi: assert property (p_eoi)
		else $error("end of interrupt did not end treatment");

	property p_spu_store;
		w_wait && hit(paddr, `ICR_A_SPU) |=> s_r.spu == $past(pwdata);
	endproperty
	a_spu_store: assert property (p_spu_store)
		else $error("spurious vector not stored");

	property p_ivr_spur;
		s_ivr_read_spur |=> pready && prdata == s_r.spu;
	endproperty
	a_ivr_spur: assert property (p_ivr_spur)
		else $error("spurious normal read returned wrong value");

	property p_fvr_spur;
		r_wait && hit(paddr, `ICR_A_FVR) && !(|fast_req) |=>
			pready && prdata == s_r.spu;
	endproperty
	a_fvr_spur: assert property (p_fvr_spur)
		else $error("spurious fast read returned wrong value");

	property p_dcr;
		w_wait && hit(paddr, `ICR_A_DCR) |=> s_r.dcr == $past(pwdata[1:0]);
	endproperty
	a_dcr: assert property (p_dcr)
		else $error("debug control not stored");

	property p_general_line_mask;
		s_r.dcr[`ICR_DCR_LINE_MASK] |=> normal_irq_out_n && fast_irq_out_n;
	endproperty
	a_general_line_mask: assert property (p_general_line_mask)
		else $error("request line active under general mask");

	property p_ffer;
		w_wait && hit(paddr, `ICR_A_FFER) |=>
			((s_r.ffs & $past(pwdata)) | 32'h1) == ($past(pwdata) | 32'h1);
	endproperty
	a_ffer: assert property (p_ffer)
		else $error("fast forcing not enabled");

	property p_ffdr;
		w_wait && hit(paddr, `ICR_A_FFDR) |=> (s_r.ffs & $past(pwdata)) == 0;
	endproperty
	a_ffdr: assert property (p_ffdr)
		else $error("fast forcing not disabled");

	property p_ffsr;
		r_wait && hit(paddr, `ICR_A_FFSR) |=>
			prdata == s_r.ffs && !prdata[0];
	endproperty
	a_ffsr: assert property (p_ffsr)
		else $error("fast forcing status wrong");

	property p_protection_enable;
		r_wait && hit(paddr, `ICR_A_IVR) && s_r.dcr[`ICR_DCR_PROTECT_EN] |=>
			s_r.cur_valid == $past(s_r.cur_valid) &&
			s_r.cur_id == $past(s_r.cur_id);
	endproperty
	a_protection_enable: assert property (p_protection_enable)
		else $error("protected read changed interrupt state");

endmodule

// [testbench/icr_src_model.sv]
// Interrupt source model: turns bench requests into source edges
`timescale 1ns/1ps
module icr_src_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bench request, one cycle per edge wanted
	input wire logic [31:0] fire,
	// Source lines towards the block
	output logic [31:0] src_irq
);
	// A one-cycle pulse gives the clean rising edge the block samples
	always_ff @(posedge core_clk) begin
		if (rst) begin
			src_irq <= 32'h0;
		end else begin
			src_irq <= fire;
		end
	end
endmodule

// [testbench/icr_cmd_regs_bench.sv]
// Self-checking bench of the command register block
`timescale 1ns/1ps
`include "icr_params.svh"
module icr_cmd_regs_bench;
	logic core_clk = 0;
	logic rst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] fire = 32'h0;
	logic [31:0] src_irq;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic normal_irq_out_n;
	logic fast_irq_out_n;
	logic irq_out;
	logic [31:0] rd_v;
	logic err_v;
	int bad_count = 0;
	int checks_done = 0;

	always #2 core_clk = ~core_clk;

	icr_cmd_regs icr_cmd_regs_i (.core_clk(core_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_irq(src_irq),
		.normal_irq_out_n(normal_irq_out_n),
		.fast_irq_out_n(fast_irq_out_n), .irq_out(irq_out));
	icr_src_model icr_src_model_i (.core_clk(core_clk), .rst(rst),
		.fire(fire), .src_irq(src_irq));

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic complete_run;
		if (bad_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until pready is sampled high at a rising edge
	task automatic xf(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			complete_run();
		end
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, d);
		xf(1'b1, a, d);
	endtask

	task automatic rc(input logic [31:0] a, e);
		xf(1'b0, a, 32'h0);
		chk(rd_v, e);
	endtask

	// Lines settle one cycle after their cause; three cycles is margin
	task automatic lc(input logic n, f);
		repeat (3) @(posedge core_clk);
		chk({30'h0, normal_irq_out_n, fast_irq_out_n}, {30'h0, n, f});
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rc(`ICR_A_SPU, 32'h0);
		rc(`ICR_A_DCR, 32'h0);
		rc(`ICR_A_FFSR, 32'h0);
		wr(`ICR_A_SPU, 32'h5a5a_0f0f);
		rc(`ICR_A_SPU, 32'h5a5a_0f0f);
		for (int i = 0; i < 6; i++) begin
			wr(`ICR_A_SVR_BASE + 32'(4 * i), 32'h100 + 32'(i));
		end
		wr(`ICR_A_IECR, 32'h3f);
		rc(`ICR_A_IVR, 32'h5a5a_0f0f);
		rc(`ICR_A_FVR, 32'h5a5a_0f0f);
		wr(`ICR_A_ISCR, 32'h0c);
		rc(`ICR_A_IPR, 32'h0c);
		lc(1'b0, 1'b1);
		rc(`ICR_A_IVR, 32'h102);
		rc(`ICR_A_ISR, 32'h2);
		rc(`ICR_A_IPR, 32'h08);
		lc(1'b1, 1'b1);
		wr(`ICR_A_EOICR, 32'hdead_beef);
		lc(1'b0, 1'b1);
		rc(`ICR_A_IVR, 32'h103);
		wr(`ICR_A_EOICR, 32'h0);
		wr(`ICR_A_ISCR, 32'h30);
		wr(`ICR_A_ICCR, 32'h10);
		rc(`ICR_A_IPR, 32'h20);
		wr(`ICR_A_ICCR, 32'h20);
		wr(`ICR_A_ISCR, 32'h1);
		lc(1'b1, 1'b0);
		rc(`ICR_A_FVR, 32'h100);
		rc(`ICR_A_IPR, 32'h0);
		wr(`ICR_A_FFER, 32'hffff_ffff);
		rc(`ICR_A_FFSR, 32'hffff_fffe);
		wr(`ICR_A_FFDR, 32'hffff_ffdf);
		rc(`ICR_A_FFSR, 32'h20);
		wr(`ICR_A_FFDR, 32'h0);
		rc(`ICR_A_FFSR, 32'h20);
		wr(`ICR_A_ISCR, 32'h20);
		lc(1'b1, 1'b0);
		wr(`ICR_A_DCR, 32'h2);
		lc(1'b1, 1'b1);
		rc(`ICR_A_DCR, 32'h2);
		wr(`ICR_A_DCR, 32'h0);
		lc(1'b1, 1'b0);
		wr(`ICR_A_ICCR, 32'h20);
		wr(`ICR_A_FFDR, 32'h20);
		wr(`ICR_A_DCR, 32'h1);
		wr(`ICR_A_ISCR, 32'h4);
		rc(`ICR_A_IVR, 32'h102);
		rc(`ICR_A_IPR, 32'h4);
		wr(`ICR_A_IVR, 32'h0);
		rc(`ICR_A_IPR, 32'h0);
		rc(`ICR_A_ISR, 32'h2);
		wr(`ICR_A_EOICR, 32'h0);
		wr(`ICR_A_DCR, 32'h0);
		@(posedge core_clk);
		fire <= 32'h10;
		@(posedge core_clk);
		fire <= 32'h0;
		rc(`ICR_A_IPR, 32'h10);
		wr(`ICR_A_ICCR, 32'h10);
		rc(`ICR_A_EVT_STAT, 32'h7);
		wr(`ICR_A_EVT_EN, 32'h2);
		lc(1'b1, 1'b1);
		chk({31'h0, irq_out}, 32'h1);
		wr(`ICR_A_EVT_EN, 32'h0);
		lc(1'b1, 1'b1);
		chk({31'h0, irq_out}, 32'h0);
		wr(`ICR_A_EVT_CLR, 32'h7);
		rc(`ICR_A_EVT_STAT, 32'h0);
		xf(1'b0, 32'hffff_f13c, 32'h0);
		chk({31'h0, err_v}, 32'h1);
		complete_run();
	end
endmodule
